// File: hdl/ftm_channel.v
// Functional notes
// - Monitor enable turns the tach pin into a speed input.
// - Enable overrides all other pin setup except bypass select bits.
// - With bypass bits set the pin is an output even when monitoring.
// - With monitor enable clear, interrupt enable and divisor do nothing.
// - Tach pulses gate the 20 kHz tick into an eight-bit counter.
// - Two pulses make one revolution; divisor picks one of four ranges.
// - Tach input is synchronised and filtered against slow edges.
// - With interrupt enable set, count at or above limit flags interrupt.
// - Interrupt drives the low-active pin and loads source with control index.
// - With interrupt enable clear no overflow condition arises; the revolution flag still sets.
// - Divisor codes 00..11 give divide by 1, 2, 4, 8.
// - Count is 20 kHz ticks per revolution over the divisor.
// - Polled mode refreshes current count every revolution.
// - After an interrupt the current count holds until cleared.
// - Clearing the interrupt zeroes the current count.
// - Counter saturates at all ones for slow or absent pulses.
`include "ftm_map.vh"

module ftm_channel #(
	parameter TICK_CYCLES = `FTM_TICK_CYCLES
) (
	input  wire        core_clk,     // 100 MHz clock
	input  wire        rst,          // Synchronous reset, high
	input  wire        psel,         // APB select
	input  wire        penable,      // APB access phase
	input  wire        pwrite,       // APB direction
	input  wire [7:0]  paddr,        // APB byte address
	input  wire [31:0] pwdata,       // APB write data
	output wire        pready,       // APB ready
	output reg  [31:0] prdata,       // APB read data
	output wire        pslverr,      // APB error, unmapped
	input  wire        tachPinIn,    // Tach pin input level
	output reg         tachPinOut,   // Tach pin output value
	output reg         tachPinOe,    // Tach pin output enable
	input  wire        gpioOut,      // Port logic output value
	input  wire        gpioOe,       // Port logic output enable
	input  wire [1:0]  bypassSel,    // Bypass select bits 6:5
	input  wire        bypassOut,    // Bypass output value
	output wire        irq,          // Interrupt, high active
	output wire        irqN          // Interrupt pin, low active
);

	// ************************************************************
	// Registers and state
	// ************************************************************
	reg  [7:0]                 ctrl_r;
	reg  [7:0]                 limit_r;
	reg  [7:0]                 curCount_r;
	reg  [7:0]                 curCount_nxt;
	reg  [7:0]                 counter_r;
	reg  [7:0]                 counter_nxt;
	reg  [2:0]                 preCnt_r;
	reg  [2:0]                 preCnt_nxt;
	reg                        armed_r;
	reg                        armed_nxt;
	reg                        halfRev_r;
	reg                        halfRev_nxt;
	reg  [`FTM_IRQ_WIDTH-1:0]  irqStat_r;
	reg  [`FTM_IRQ_WIDTH-1:0]  irqStat_nxt;
	reg  [`FTM_IRQ_WIDTH-1:0]  irqMask_r;
	reg  [7:0]                 irqSrc_r;
	reg  [7:0]                 irqSrc_nxt;

	wire       tick20k;
	wire       tachLevel;
	wire       tachRise;
	wire       monEn;
	wire       irqEn;
	wire [1:0] divSel;
	wire [2:0] preLast;
	wire [5:0] regIdx;
	wire       wrAcc;
	wire       rdSetup;
	wire       idxHit;
	wire       ovfEvent;
	wire       revEvent;
	wire       ovfClear;
	wire       revClear;
	wire       frozen;

	// ************************************************************
	// Slow tick and input conditioning
	// ************************************************************
	ftm_tick_div #(
		.CYCLES (TICK_CYCLES)
	) uTick (
		.core_clk (core_clk),
		.rst      (rst),
		.tick     (tick20k)
	);

	// Filter sampled at the 20 kHz rate, far above any tach rate
	ftm_tach_filter uFilt (
		.core_clk (core_clk),
		.rst      (rst),
		.sampleEn (tick20k),
		.pinIn    (tachPinIn),
		.level    (tachLevel),
		.riseStb  (tachRise)
	);

	// ************************************************************
	// Control field decode
	// ************************************************************
	assign monEn   = ctrl_r[`FTM_CTRL_EN_BIT];
	assign irqEn   = monEn && ctrl_r[`FTM_CTRL_IEN_BIT];
	assign divSel  = monEn ? ctrl_r[`FTM_CTRL_DIV_HI:`FTM_CTRL_DIV_LO] : 2'h0;
	// Divide by 1, 2, 4, 8: prescaler wraps at divisor minus one
	assign preLast = (3'h1 << divSel) - 3'h1;

	// ************************************************************
	// Pin direction mux
	// ************************************************************
	// Bypass select beats monitoring, monitoring beats port setup
	always @(posedge core_clk) begin
		if (rst) begin
			tachPinOut <= 1'b0;
			tachPinOe  <= 1'b0;
		end else if (bypassSel != 2'h0) begin
			tachPinOut <= bypassOut;
			tachPinOe  <= 1'b1;
		end else if (monEn) begin
			tachPinOut <= 1'b0;
			tachPinOe  <= 1'b0;
		end else begin
			tachPinOut <= gpioOut;
			tachPinOe  <= gpioOe;
		end
	end

	// ************************************************************
	// APB decode
	// ************************************************************
	assign regIdx  = paddr[7:2];
	assign wrAcc   = psel && penable && pwrite && idxHit;
	assign rdSetup = psel && !penable;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !idxHit;

	// Mapped indices only; the two low address bits are ignored
	assign idxHit = (regIdx == `FTM_IDX_CTRL)     || (regIdx == `FTM_IDX_LIMIT) ||
	                (regIdx == `FTM_IDX_COUNT)    || (regIdx == `FTM_IDX_IRQ_STAT) ||
	                (regIdx == `FTM_IDX_IRQ_MASK) || (regIdx == `FTM_IDX_IRQ_SRC);

	// Software-written registers
	always @(posedge core_clk) begin
		if (rst) begin
			ctrl_r    <= `FTM_RST_CTRL;
			limit_r   <= `FTM_RST_LIMIT;
			irqMask_r <= `FTM_RST_IRQ_MASK;
		end else if (wrAcc) begin
			if (regIdx == `FTM_IDX_CTRL) begin
				ctrl_r <= pwdata[7:0] & `FTM_CTRL_WMASK;
			end else if (regIdx == `FTM_IDX_LIMIT) begin
				limit_r <= pwdata[7:0];
			end else if (regIdx == `FTM_IDX_IRQ_MASK) begin
				irqMask_r <= pwdata[`FTM_IRQ_WIDTH-1:0];
			end
		end
	end

	// Read data latched in setup so it is stable in access
	always @(posedge core_clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (rdSetup) begin
			if (regIdx == `FTM_IDX_CTRL) begin
				prdata <= {24'h000000, ctrl_r};
			end else if (regIdx == `FTM_IDX_LIMIT) begin
				prdata <= {24'h000000, limit_r};
			end else if (regIdx == `FTM_IDX_COUNT) begin
				prdata <= {24'h000000, curCount_r};
			end else if (regIdx == `FTM_IDX_IRQ_STAT) begin
				prdata <= {30'h0, irqStat_r};
			end else if (regIdx == `FTM_IDX_IRQ_MASK) begin
				prdata <= {30'h0, irqMask_r};
			end else if (regIdx == `FTM_IDX_IRQ_SRC) begin
				prdata <= {24'h000000, irqSrc_r};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// ************************************************************
	// Interrupt events
	// ************************************************************
	// Overflow compare is gated by interrupt enable
	assign ovfEvent = irqEn && (counter_r >= limit_r);
	assign frozen   = irqStat_r[`FTM_IRQ_OVF_BIT];
	assign ovfClear = wrAcc && (regIdx == `FTM_IDX_IRQ_STAT) && pwdata[`FTM_IRQ_OVF_BIT];
	assign revClear = wrAcc && (regIdx == `FTM_IDX_IRQ_STAT) && pwdata[`FTM_IRQ_REV_BIT];
	// A count transfer happening this cycle raises the revolution event
	assign revEvent = monEn && armed_r && halfRev_r && tachRise && !(frozen && !ovfClear);

	// Sticky status, a same-cycle event wins over the clear
	always @* begin
		irqStat_nxt = irqStat_r;
		irqSrc_nxt  = irqSrc_r;
		if (ovfClear) begin
			irqStat_nxt[`FTM_IRQ_OVF_BIT] = 1'b0;
			irqSrc_nxt                    = `FTM_RST_IRQ_SRC;
		end
		if (revClear) begin
			irqStat_nxt[`FTM_IRQ_REV_BIT] = 1'b0;
		end
		if (ovfEvent) begin
			irqStat_nxt[`FTM_IRQ_OVF_BIT] = 1'b1;
			irqSrc_nxt                    = `FTM_IDX_CTRL;
		end
		if (revEvent) begin
			irqStat_nxt[`FTM_IRQ_REV_BIT] = 1'b1;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			irqStat_r <= {`FTM_IRQ_WIDTH{1'b0}};
			irqSrc_r  <= `FTM_RST_IRQ_SRC;
		end else begin
			irqStat_r <= irqStat_nxt;
			irqSrc_r  <= irqSrc_nxt;
		end
	end

	// Level outputs, low-active pin mirrors the high one
	assign irq  = |(irqStat_r & irqMask_r);
	assign irqN = !irq;

	// ************************************************************
	// Revolution counter
	// ************************************************************
	// First filtered rise after enable or clear only arms the
	// measurement, so the first transfer covers a whole revolution
	always @* begin
		counter_nxt  = counter_r;
		preCnt_nxt   = preCnt_r;
		armed_nxt    = armed_r;
		halfRev_nxt  = halfRev_r;
		curCount_nxt = curCount_r;
		if (!monEn) begin
			counter_nxt  = 8'h00;
			preCnt_nxt   = 3'h0;
			armed_nxt    = 1'b0;
			halfRev_nxt  = 1'b0;
			curCount_nxt = `FTM_RST_COUNT;
		end else begin
			// Tick gated into the counter through the divisor prescaler
			if (tick20k) begin
				if (preCnt_r >= preLast) begin
					preCnt_nxt = 3'h0;
					if (counter_r != `FTM_COUNT_MAX) begin
						counter_nxt = counter_r + 8'h01;
					end
				end else begin
					preCnt_nxt = preCnt_r + 3'h1;
				end
			end
			if (tachRise) begin
				if (!armed_r) begin
					armed_nxt   = 1'b1;
					halfRev_nxt = 1'b0;
					counter_nxt = 8'h00;
					preCnt_nxt  = 3'h0;
				end else if (halfRev_r) begin
					// Second pulse closes one revolution
					halfRev_nxt = 1'b0;
					if (!frozen || ovfClear) begin
						// Tick landing on the closing rise still counts
						curCount_nxt = counter_nxt;
					end
					counter_nxt = 8'h00;
					preCnt_nxt  = 3'h0;
				end else begin
					halfRev_nxt = 1'b1;
				end
			end
			// Freeze holds the reading; a real clear restarts it
			if (frozen && !ovfClear) begin
				curCount_nxt = curCount_r;
			end
			if (ovfClear && !ovfEvent) begin
				curCount_nxt = 8'h00;
				counter_nxt  = 8'h00;
				preCnt_nxt   = 3'h0;
				armed_nxt    = 1'b0;
				halfRev_nxt  = 1'b0;
			end
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			counter_r  <= 8'h00;
			preCnt_r   <= 3'h0;
			armed_r    <= 1'b0;
			halfRev_r  <= 1'b0;
			curCount_r <= `FTM_RST_COUNT;
		end else begin
			counter_r  <= counter_nxt;
			preCnt_r   <= preCnt_nxt;
			armed_r    <= armed_nxt;
			halfRev_r  <= halfRev_nxt;
			curCount_r <= curCount_nxt;
		end
	end

endmodule // ftm_channel

// File: hdl/ftm_map.vh
`ifndef FTM_MAP_VH
`define FTM_MAP_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define FTM_IDX_CTRL        8'h34
`define FTM_IDX_LIMIT       8'h35
`define FTM_IDX_COUNT       8'h36
`define FTM_IDX_IRQ_STAT    8'h38
`define FTM_IDX_IRQ_MASK    8'h39
`define FTM_IDX_IRQ_SRC     8'h3a

// ************************************************************
// Control register fields
// ************************************************************
`define FTM_CTRL_EN_BIT     7
`define FTM_CTRL_IEN_BIT    6
`define FTM_CTRL_DIV_HI     1
`define FTM_CTRL_DIV_LO     0
`define FTM_CTRL_WMASK      8'hc3

// ************************************************************
// Interrupt status fields
// ************************************************************
`define FTM_IRQ_OVF_BIT     0
`define FTM_IRQ_REV_BIT     1
`define FTM_IRQ_WIDTH       2

// ************************************************************
// Reset values
// ************************************************************
`define FTM_RST_CTRL        8'h00
`define FTM_RST_LIMIT       8'h00
`define FTM_RST_COUNT       8'h00
`define FTM_RST_IRQ_MASK    2'h0
`define FTM_RST_IRQ_SRC     8'h00

// ************************************************************
// Timing
// ************************************************************
`define FTM_CLK_PERIOD_NS   10
`define FTM_TICK_PERIOD_NS  50000
`define FTM_TICK_CYCLES     (`FTM_TICK_PERIOD_NS / `FTM_CLK_PERIOD_NS)
`define FTM_FILT_SAMPLES    3
`define FTM_COUNT_MAX       8'hff

`endif

// File: hdl/ftm_tick_div.v
// ************************************************************
// Divider producing a one-cycle enable pulse
// ************************************************************
module ftm_tick_div #(
	parameter CYCLES = 5000
) (
	input  wire core_clk,   // System clock
	input  wire rst,        // Synchronous reset
	output reg  tick        // One-cycle pulse every CYCLES clocks
);

	reg [15:0] cnt_r;

	// Free-running count, pulse on wrap
	always @(posedge core_clk) begin
		if (rst) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b0;
		end else if (cnt_r == CYCLES[15:0] - 16'h0001) begin
			cnt_r <= 16'h0000;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			tick  <= 1'b0;
		end
	end

endmodule // ftm_tick_div

// File: hdl/ftm_tach_filter.v
`include "ftm_map.vh"

// ************************************************************
// Tach pin synchroniser and slow-edge filter
// ************************************************************
module ftm_tach_filter (
	input  wire core_clk,   // System clock
	input  wire rst,        // Synchronous reset
	input  wire sampleEn,   // Filter sample enable
	input  wire pinIn,      // Raw asynchronous tach level
	output reg  level,      // Filtered tach level
	output wire riseStb     // One-cycle pulse on filtered rise
);

	reg       sync1_r;
	reg       sync2_r;
	reg [1:0] agree_r;

	// Two-stage synchroniser; stage one feeds stage two only.
	// Resets to the pulled-up idle level, so no false rise follows reset
	always @(posedge core_clk) begin
		if (rst) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= pinIn;
			sync2_r <= sync1_r;
		end
	end

	// Level moves only after several agreeing slow samples,
	// so a slow edge chattering through threshold counts once
	always @(posedge core_clk) begin
		if (rst) begin
			agree_r <= 2'h0;
			level   <= 1'b1;
		end else if (sampleEn) begin
			if (sync2_r == level) begin
				agree_r <= 2'h0;
			end else if (agree_r == `FTM_FILT_SAMPLES - 1) begin
				agree_r <= 2'h0;
				level   <= sync2_r;
			end else begin
				agree_r <= agree_r + 2'h1;
			end
		end
	end

	assign riseStb = sampleEn && !level && (sync2_r != level) && (agree_r == `FTM_FILT_SAMPLES - 1);

endmodule // ftm_tach_filter

// File: verif/ftm_channel_checker.sv
// ****************
// Channel checker
// ****************
module ftm_channel_checker #(
	parameter TICK_CYCLES = 20
) (
	input wire        core_clk,   // Clock
	input wire        rst,        // Reset
	input wire        psel,       // Select
	input wire        penable,    // Access
	input wire        pwrite,     // Write
	input wire [7:0]  paddr,      // Address
	input wire [31:0] pwdata,     // Data
	input wire        pready,     // Ready
	input wire        pslverr,    // Error
	input wire        tachPinOut, // Pin value
	input wire        tachPinOe,  // Pin enable
	input wire        gpioOut,    // Port value
	input wire        gpioOe,     // Port enable
	input wire [1:0]  bypassSel,  // Bypass bits
	input wire        bypassOut,  // Bypass value
	input wire        irq,        // Interrupt
	input wire        irqN        // Int pin
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic [7:0] ctrl_r;
	logic [7:0] limit_r;
	logic [1:0] mask_r;
	wire        wrEn = psel && penable && pwrite;
	wire        unmapped = !(paddr[7:2] inside {6'h34, 6'h35, 6'h36, 6'h38, 6'h39, 6'h3a});

	// Shadow of software writes, so pin and irq can be tied to them
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r  <= 8'h00;
			limit_r <= 8'h00;
			mask_r  <= 2'h0;
		end else if (wrEn) begin
			if (paddr == 8'hd0) ctrl_r <= pwdata[7:0];
			if (paddr == 8'hd4) limit_r <= pwdata[7:0];
			if (paddr == 8'he4) mask_r <= pwdata[1:0];
		end
	end

	// Past enable checked too, in case the overflow test is pipelined
	sequence s_quiet;
		!ctrl_r[6] && !$past(ctrl_r[6]) && !mask_r[1] && !irq && !(wrEn && paddr == 8'he4);
	endsequence
	sequence s_arm;
		wrEn && paddr == 8'hd0 && pwdata[7:6] == 2'b11 && limit_r == 8'h00 && mask_r[0];
	endsequence
	property p_quiet;
		s_quiet |=> !irq;
	endproperty
	property p_zero_limit;
		s_arm |-> ##[1:3] irq;
	endproperty
	property p_bypass;
		bypassSel != 2'b00 |=> tachPinOe && tachPinOut == $past(bypassOut);
	endproperty
	property p_monitor;
		ctrl_r[7] && bypassSel == 2'b00 |=> !tachPinOe;
	endproperty
	property p_gpio;
		!ctrl_r[7] && bypassSel == 2'b00 |=> tachPinOe == $past(gpioOe) && tachPinOut == $past(gpioOut);
	endproperty
	property p_irq_pin;
		irqN == !irq;
	endproperty
	property p_ready;
		psel && penable |-> pready;
	endproperty
	property p_slverr;
		psel && penable |-> pslverr == unmapped;
	endproperty

	a_quiet: assert property (p_quiet) else $error("irq rose while disabled");
	a_zero_limit: assert property (p_zero_limit) else $error("no irq at zero limit");
	a_bypass: assert property (p_bypass) else $error("bypass not driven");
	a_monitor: assert property (p_monitor) else $error("pin not an input");
	a_gpio: assert property (p_gpio) else $error("port setting lost");
	a_irq_pin: assert property (p_irq_pin) else $error("irq pin not inverse");
	a_ready: assert property (p_ready) else $error("ready low");
	a_slverr: assert property (p_slverr) else $error("wrong error response");
endmodule // ftm_channel_checker

bind ftm_channel ftm_channel_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// File: verif/ftm_fan_model.sv
// ****************
// Fan tach model
// ****************
module ftm_fan_model (
	input  wire        run,        // Fan spinning
	input  wire [15:0] halfCycles, // Half pulse, clocks
	output logic       tach        // Tach output
);
	timeunit 1ns;
	timeprecision 1ps;

	// Two pulses a turn; a stopped fan rests at the pull-up level
	always begin
		tach = 1'b1;
		wait (run);
		repeat (2) begin
			// Ringing on each edge, far shorter than a filter window
			repeat (3) begin
				tach = ~tach;
				#30;
			end
			#(halfCycles * 10 - 90);
		end
	end
endmodule // ftm_fan_model

// File: verif/test_fan_tach_monitor_channel.sv
// ****************
// Channel testbench
// ****************
module test_fan_tach_monitor_channel;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TICK = 20;  // Clocks per sample tick
	localparam int HALF = 200; // Turn of 40 ticks fits eight bits
	localparam logic [7:0] A_CTRL = 8'hd0;
	localparam logic [7:0] A_LIM  = 8'hd4;
	localparam logic [7:0] A_CNT  = 8'hd8;
	localparam logic [7:0] A_STAT = 8'he0;
	localparam logic [7:0] A_MASK = 8'he4;
	localparam logic [7:0] A_SRC  = 8'he8;

	logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic        tachPinIn, tachPinOut, tachPinOe, gpioOut, gpioOe, bypassOut, irq, irqN, fanRun;
	logic [1:0]  bypassSel;
	logic [7:0]  paddr;
	logic [15:0] fanHalf;
	logic [31:0] pwdata, prdata, rdat;
	int          errors, testsRun;

	ftm_channel #(.TICK_CYCLES(TICK)) i_dut (.*);
	ftm_fan_model i_fan (.run(fanRun), .halfCycles(fanHalf), .tach(tachPinIn));

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Watchdog, well past the expected run
	initial begin
		repeat (90000) @(posedge core_clk);
		errors++;
		$display("mismatch watchdog exp done got hang");
		endSim();
	end

	task automatic endSim();
		$display("comparisons %0d errors %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Compare; tol absorbs one tick of tach phase slip
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int tol = 0);
		testsRun++;
		if ($isunknown(g) || g + tol < e || g > e + tol) begin
			errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	// One transfer; idle edge after it so no signal is set twice at once
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Wait as long as the slave asks; only the watchdog ends a hang
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		chk("pready", 1, pready);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rdChk(input logic [7:0] a, input string nm, input logic [31:0] e, input int tol = 0);
		apb(a, 1'b0, 32'h0);
		chk(nm, e, rdat, tol);
	endtask

	// Clear the new-count flag, then poll for the next transfer
	task automatic waitRev();
		int n;
		apb(A_STAT, 1'b1, 32'h2);
		n = 0;
		do begin
			apb(A_STAT, 1'b0, 32'h0);
			n++;
		end while (rdat[1] !== 1'b1 && n < 6000);
		chk("new count flag", 1, rdat[1]);
	endtask

	// Reset values, reserved and read-only bits, unmapped place
	task automatic t_regs();
		logic [7:0] regs [6];
		regs = '{A_CTRL, A_LIM, A_CNT, A_STAT, A_MASK, A_SRC};
		foreach (regs[i]) begin
			rdChk(regs[i], "reset value", 32'h0);
			chk("mapped err", 0, rerr);
		end
		apb(A_CTRL, 1'b1, 32'h3c);
		rdChk(A_CTRL, "reserved bits", 32'h0);
		apb(A_LIM, 1'b1, 32'ha5);
		rdChk(A_LIM, "limit", 32'ha5);
		apb(A_CNT, 1'b1, 32'hff);
		rdChk(A_CNT, "count read only", 32'h0);
		rdChk(8'hfc, "unmapped data", 32'h0);
		chk("unmapped err", 1, rerr);
	endtask

	// Pin ownership: port logic, monitor input, bypass output
	task automatic t_pins();
		gpioOe  <= 1'b1;
		gpioOut <= 1'b1;
		apb(A_CTRL, 1'b1, 32'h43);
		chk("oe monitor off", 1, tachPinOe);
		chk("out monitor off", 1, tachPinOut);
		apb(A_CTRL, 1'b1, 32'h80);
		// Pin mux is registered one edge behind the control write
		@(posedge core_clk);
		chk("oe monitor on", 0, tachPinOe);
		bypassSel <= 2'b10;
		bypassOut <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("oe bypass", 1, tachPinOe);
		chk("out bypass", 1, tachPinOut);
		bypassSel <= 2'b00;
		bypassOut <= 1'b0;
		apb(A_CTRL, 1'b1, 32'h0);
	endtask

	// Polled turn counts for every divisor code, two turns each
	task automatic t_measure();
		fanRun <= 1'b1;
		for (int code = 0; code < 4; code++) begin
			apb(A_CTRL, 1'b1, 32'h0);
			apb(A_CTRL, 1'b1, 32'h80 | code);
			repeat (2) begin
				waitRev();
				rdChk(A_CNT, "turn count", (4 * HALF / TICK) >> code, 1);
			end
		end
	endtask

	// A turn of 300 ticks must pin the count at all ones
	task automatic t_slow();
		apb(A_CTRL, 1'b1, 32'h0);
		fanHalf <= 16'd1500;
		apb(A_CTRL, 1'b1, 32'h80);
		waitRev();
		rdChk(A_CNT, "saturated count", 32'hff);
	endtask

	// Overflow: masked, raised, count frozen, then cleared
	task automatic t_irq();
		apb(A_CTRL, 1'b1, 32'h0);
		fanHalf <= HALF;
		apb(A_LIM, 1'b1, 32'h20);
		apb(A_CTRL, 1'b1, 32'h80);
		waitRev();
		apb(A_CTRL, 1'b1, 32'hc0);
		repeat (1500) @(posedge core_clk);
		chk("irq masked", 0, irq);
		apb(A_MASK, 1'b1, 32'h1);
		chk("irq raised", 1, irq);
		chk("irq pin", 0, irqN);
		rdChk(A_SRC, "irq source", 32'h34);
		fanHalf <= HALF / 2;
		repeat (2000) @(posedge core_clk);
		rdChk(A_CNT, "frozen count", 4 * HALF / TICK, 1);
		apb(A_CTRL, 1'b1, 32'h80);
		apb(A_STAT, 1'b1, 32'h1);
		rdChk(A_CNT, "count after clear", 32'h0);
		rdChk(A_SRC, "source after clear", 32'h0);
		chk("irq cleared", 0, irq);
		apb(A_LIM, 1'b1, 32'h08);
		repeat (2000) @(posedge core_clk);
		chk("irq enable clear", 0, irq);
		apb(A_LIM, 1'b1, 32'h0);
		apb(A_CTRL, 1'b1, 32'hc0);
		// Status sets one edge after the enable lands
		@(posedge core_clk);
		chk("irq zero limit", 1, irq);
		apb(A_CTRL, 1'b1, 32'h0);
		apb(A_STAT, 1'b1, 32'h3);
		fanRun <= 1'b0;
	endtask

	// Reset for 12 cycles, then the scenarios in turn
	initial begin
		{rst, psel, penable, pwrite, gpioOut, gpioOe, bypassOut, fanRun} = 8'h80;
		bypassSel = 2'b00;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		fanHalf   = HALF;
		errors    = 0;
		testsRun  = 0;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_regs();
		t_pins();
		t_measure();
		t_slow();
		t_irq();
		endSim();
	end
endmodule // test_fan_tach_monitor_channel
